// File: olps_consts.svh
`ifndef OLPS_CONSTS_SVH
`define OLPS_CONSTS_SVH
`define OLPS_CLK_HZ            20000000
`define OLPS_FAIL_HZ           5000
`define OLPS_FAIL_CYC          (`OLPS_CLK_HZ / `OLPS_FAIL_HZ)
`define OLPS_WAKE_MS           2000
`define OLPS_WAKE_CYC          (`OLPS_CLK_HZ / 1000 * `OLPS_WAKE_MS)
`define OLPS_ADDR_CTRL         8'h00
`define OLPS_ADDR_CHAN0        8'h04
`define OLPS_ADDR_GDUTY1       8'h24
`define OLPS_ADDR_GDUTY2       8'h28
`define OLPS_ADDR_STATUS       8'h2C
`define OLPS_ADDR_PINS         8'h30
`define OLPS_CTRL_SYNC_BIT     8
`define OLPS_CTRL_OE_LSB       0
`define OLPS_CTRL_DDEN_LSB     16
`define OLPS_STAT_FAIL_BIT     3
`define OLPS_CH_DUTY_LSB       0
`define OLPS_CH_PHASE_LSB      9
`define OLPS_CH_SRC_LSB        11
`define OLPS_CH_GATE_LSB       13
`define OLPS_RESP_OKAY         2'h0
`define OLPS_RESP_SLVERR       2'h2
`define OLPS_DIRECT_MASK       8'h77
`endif

// File: olps_pkg.sv
package olps_pkg;
	typedef logic [7:0] olps_duty_t;
	typedef struct packed {
		logic [1:0] gate;
		logic [1:0] src;
		logic [1:0] phase;
		logic [7:0] duty;
	} olps_chan_s;
	typedef struct packed {
		logic [31:0] addr;
		logic        valid;
	} olps_req_s;
	typedef enum logic [2:0] {
		OLPS_IDLE = 3'b001,
		OLPS_RESP = 3'b010,
		OLPS_DONE = 3'b100
	} olps_bus_e;
endpackage

// File: olps_regmem.sv
`timescale 1ns/1ps
`include "olps_consts.svh"
module olps_regmem (
	input  wire logic        aclk,
	input  wire logic        we,
	input  wire logic [3:0]  waddr,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  raddr,
	output logic      [31:0] rdata
);
	// Channel words kept here; read data registered.
	logic [31:0] mem [0:7];
	always_ff @(posedge aclk) begin
		if (we && waddr < 4'h8) begin
			mem[waddr[2:0]] <= wdata;
		end
	end
	always_ff @(posedge aclk) begin
		rdata <= (raddr < 4'h8) ? mem[raddr[2:0]] : 32'h0000_0000;
	end
endmodule // olps_regmem

// File: olps_top.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "olps_consts.svh"
// Notes on behaviour
// (RULE1) 256 time-base clocks per PWM period.
// (RULE2) Time-base gap over 200 us is failure.
// (RULE3) On failure outputs follow enable bits.
// (RULE4) Failure flag sticky until read-clear.
// (RULE5) Disabled: shared pin outputs wake state.
// (RULE6) Fallback input: outputs follow direct inputs.
// (RULE7) Direct inputs ignored until enabled.
// (RULE8) Duty 00h off, FFh 255/256 on.
// (RULE9) Four phase offsets per channel.
// (RULE10) Sync bit realigns the PWM counter.
// (RULE11) Duty changes apply at counter wrap.
// (RULE12) Full off/on applies immediately.
// (RULE13) Cleared output enable forces off.
// (RULE14) Ungated: source select picks state.
// (RULE15) Individual, global one, global two duties.
// (RULE16) Gated, input low: gate select picks.
// (RULE17) Gated, input high: source select picks.
// (RULE18) Channels four, eight use source only.
// (RULE19) Enable pin chooses standby or active.
// (RULE20) Channel on while phased count below duty.
module olps_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        enable_pin,
	input  wire logic        fallback_pin,
	input  wire logic [7:0]  direct_drive_input,
	input  wire logic        clk_wake_pin_i,
	output logic             clk_wake_pin_o,
	output logic             clk_wake_pin_oe,
	output logic      [7:0]  channel_out
);
	import olps_pkg::*;

	localparam logic [7:0] DIRECT_MASK = `OLPS_DIRECT_MASK;

	function automatic logic duty_on(input logic [7:0] cnt, input logic [1:0] ph,
		input logic [7:0] duty);
		logic [7:0] c;
		c = cnt - {ph, 6'h00};
		duty_on = c < duty;
	endfunction

	function automatic logic [1:0] pick_src(input logic [1:0] gate, input logic [1:0] src,
		input logic din, input logic has_in);
		if (!has_in || gate == 2'h0 || din) begin
			pick_src = src;
		end else begin
			pick_src = (gate == 2'h3) ? 2'h0 : gate;
		end
	endfunction

	// Pins are synchronised before any logic reads them.
	logic [11:0] s1_r;
	logic [11:0] s2_r;
	logic        tb_d_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r   <= 12'h000;
			s2_r   <= 12'h000;
			tb_d_r <= 1'b0;
		end else begin
			s1_r   <= {clk_wake_pin_i, fallback_pin, enable_pin, direct_drive_input, 1'b0};
			s2_r   <= s1_r;
			tb_d_r <= s2_r[11];
		end
	end
	wire       en_s   = s2_r[9];
	wire       fb_s   = s2_r[10];
	wire [7:0] din_s  = s2_r[8:1];
	wire       tb_s   = s2_r[11];
	wire       tb_rise = tb_s & ~tb_d_r;

	// Control registers.
	logic [31:0] ctrl_r;
	logic [7:0]  gd1_r;
	logic [7:0]  gd2_r;
	logic        fail_flag_r;
	wire  [7:0]  oe_bits = ctrl_r[`OLPS_CTRL_OE_LSB +: 8];
	wire  [7:0]  dd_en   = ctrl_r[`OLPS_CTRL_DDEN_LSB +: 8];

	// Channel shadow copies kept in flops for the datapath.
	olps_chan_s  ch_r  [0:7];
	olps_chan_s  act_r [0:7];
	logic [7:0]  agd1_r;
	logic [7:0]  agd2_r;

	// AXI write: address and data accepted in either order.
	logic        aw_have_r;
	logic        w_have_r;
	logic        aw_ok_r;
	logic [7:0]  waddr_r;
	logic [31:0] wdata_r;
	wire         wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	wire         ch_hit = wr_go && aw_ok_r && waddr_r >= `OLPS_ADDR_CHAN0 &&
		waddr_r < `OLPS_ADDR_GDUTY1;
	wire  [3:0]  ch_idx = 4'((waddr_r - `OLPS_ADDR_CHAN0) >> 2);
	wire         known_w = waddr_r == `OLPS_ADDR_CTRL || waddr_r == `OLPS_ADDR_GDUTY1 ||
		waddr_r == `OLPS_ADDR_GDUTY2 || ch_hit;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_ok_r       <= 1'b0;
			waddr_r       <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `OLPS_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready;
			s_axi_wready  <= !w_have_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_ok_r   <= s_axi_awaddr[31:8] == 24'h0;
				waddr_r   <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (known_w && aw_ok_r) ? `OLPS_RESP_OKAY : `OLPS_RESP_SLVERR;
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	wire sync_wr = wr_go && aw_ok_r && waddr_r == `OLPS_ADDR_CTRL &&
		wdata_r[`OLPS_CTRL_SYNC_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= 32'h0000_0000; // RULE7
			gd1_r  <= 8'h00;
			gd2_r  <= 8'h00;
		end else if (wr_go && aw_ok_r) begin
			if (waddr_r == `OLPS_ADDR_CTRL) begin
				ctrl_r <= wdata_r & 32'h00FF_00FF;
			end
			if (waddr_r == `OLPS_ADDR_GDUTY1) begin
				gd1_r <= wdata_r[7:0];
			end
			if (waddr_r == `OLPS_ADDR_GDUTY2) begin
				gd2_r <= wdata_r[7:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 8; i++) begin
				ch_r[i] <= '0;
			end
		end else if (ch_hit) begin
			ch_r[ch_idx[2:0]] <= olps_chan_s'({wdata_r[`OLPS_CH_PHASE_LSB +: 6], wdata_r[7:0]});
		end
	end

	// PWM counter on time-base edges; failure watchdog on aclk.
	logic [7:0]  cnt_r;
	logic [15:0] gap_r;
	logic        tb_fail_r;
	wire         wrap = tb_rise && cnt_r == 8'hFF;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 8'h00;
		end else if (sync_wr) begin
			cnt_r <= 8'h00; // RULE10
		end else if (tb_rise && en_s) begin
			cnt_r <= cnt_r + 8'h01; // RULE1 RULE20
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !en_s || tb_rise) begin
			gap_r     <= 16'h0000;
			tb_fail_r <= 1'b0;
		end else if (gap_r >= 16'(`OLPS_FAIL_CYC)) begin
			tb_fail_r <= 1'b1; // RULE2
		end else begin
			gap_r <= gap_r + 16'h0001;
		end
	end

	// Buffered duty: loaded at wrap or on a sync write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			agd1_r <= 8'h00;
			agd2_r <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				act_r[i] <= '0;
			end
		end else if (wrap || sync_wr) begin
			agd1_r <= gd1_r; // RULE11
			agd2_r <= gd2_r;
			for (int i = 0; i < 8; i++) begin
				act_r[i] <= ch_r[i];
			end
		end
	end

	// Output selection.
	logic [7:0] out_nxt;
	always_comb begin
		logic [1:0] sel;
		logic [1:0] lsel;
		logic       din_v;
		logic       has_in;
		logic       gated_off;
		logic       pw;
		sel       = 2'h0;
		lsel      = 2'h0;
		din_v     = 1'b0;
		has_in    = 1'b0;
		gated_off = 1'b0;
		pw        = 1'b0;
		out_nxt   = 8'h00;
		for (int i = 0; i < 8; i++) begin
			has_in = DIRECT_MASK[i]; // RULE18
			din_v  = din_s[i] && dd_en[i]; // RULE7
			// Buffered gate and source run the duty; live ones only force full on or off.
			sel  = pick_src(act_r[i].gate, act_r[i].src, din_v, has_in); // RULE14 RULE16 RULE17 RULE11
			lsel = pick_src(ch_r[i].gate, ch_r[i].src, din_v, has_in);
			gated_off = has_in && ch_r[i].gate == 2'h3 && !din_v;
			case (sel)
				2'h0: pw = duty_on(cnt_r, act_r[i].phase, act_r[i].duty); // RULE15 RULE9 RULE8
				2'h1: pw = duty_on(cnt_r, act_r[i].phase, agd1_r);
				2'h2: pw = duty_on(cnt_r, act_r[i].phase, agd2_r);
				default: pw = 1'b1; // RULE12
			endcase
			if (has_in && act_r[i].gate == 2'h3 && !din_v) begin
				pw = 1'b0;
			end
			if (lsel == 2'h3) begin
				pw = 1'b1; // RULE12
			end
			if (gated_off) begin
				pw = 1'b0; // RULE12
			end
			if (fb_s) begin
				out_nxt[i] = has_in && din_s[i]; // RULE6
			end else if (!en_s) begin
				out_nxt[i] = 1'b0;
			end else if (tb_fail_r) begin
				out_nxt[i] = oe_bits[i]; // RULE3
			end else begin
				out_nxt[i] = oe_bits[i] && pw; // RULE13
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_out <= 8'h00;
		end else begin
			channel_out <= out_nxt;
		end
	end

	// Wake output and timer while disabled.
	logic [31:0] wake_cnt_r;
	wire         wake_src = |(din_s & `OLPS_DIRECT_MASK);
	always_ff @(posedge aclk) begin
		if (!aresetn || en_s) begin
			wake_cnt_r <= 32'h0000_0000;
		end else if (wake_src) begin
			wake_cnt_r <= 32'(`OLPS_WAKE_CYC);
		end else if (wake_cnt_r != 32'h0000_0000) begin
			wake_cnt_r <= wake_cnt_r - 32'h0000_0001;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_wake_pin_oe <= 1'b0;
			clk_wake_pin_o  <= 1'b0;
		end else begin
			clk_wake_pin_oe <= !en_s; // RULE19
			clk_wake_pin_o  <= !en_s && (wake_src || wake_cnt_r != 32'h0000_0000); // RULE5
		end
	end

	// AXI read; status read clears the failure flag, a new failure wins.
	logic [31:0] mem_rdata;
	logic        rd_pend_r;
	logic [7:0]  raddr_r;
	wire         rd_take = s_axi_arvalid && s_axi_arready;
	wire         stat_rd = rd_take && s_axi_araddr[7:0] == `OLPS_ADDR_STATUS;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_flag_r <= 1'b0;
		end else if (tb_fail_r) begin
			fail_flag_r <= 1'b1; // RULE4
		end else if (stat_rd) begin
			fail_flag_r <= 1'b0; // RULE4
		end
	end
	olps_regmem u_mem (
		.aclk  (aclk),
		.we    (ch_hit),
		.waddr (ch_idx),
		.wdata (wdata_r),
		.raddr (4'((s_axi_araddr[7:0] - `OLPS_ADDR_CHAN0) >> 2)),
		.rdata (mem_rdata)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `OLPS_RESP_OKAY;
			rd_pend_r     <= 1'b0;
			raddr_r       <= 8'h00;
		end else begin
			s_axi_arready <= !rd_pend_r && !s_axi_rvalid && !s_axi_arready;
			if (rd_take) begin
				rd_pend_r <= 1'b1;
				raddr_r   <= s_axi_araddr[7:0];
				s_axi_rresp <= (s_axi_araddr[31:8] == 24'h0 && s_axi_araddr[7:0] <=
					`OLPS_ADDR_PINS) ? `OLPS_RESP_OKAY : `OLPS_RESP_SLVERR;
				case (s_axi_araddr[7:0])
					`OLPS_ADDR_CTRL:   s_axi_rdata <= ctrl_r;
					`OLPS_ADDR_GDUTY1: s_axi_rdata <= {24'h0, gd1_r};
					`OLPS_ADDR_GDUTY2: s_axi_rdata <= {24'h0, gd2_r};
					`OLPS_ADDR_STATUS: s_axi_rdata <= {28'h0, fail_flag_r | tb_fail_r, 3'h0};
					`OLPS_ADDR_PINS:   s_axi_rdata <= {14'h0, fb_s, en_s, cnt_r, channel_out};
					default:           s_axi_rdata <= 32'h0000_0000;
				endcase
			end
			if (rd_pend_r) begin
				rd_pend_r    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				if (raddr_r >= `OLPS_ADDR_CHAN0 && raddr_r < `OLPS_ADDR_GDUTY1) begin
					s_axi_rdata <= mem_rdata;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // olps_top

// File: olps_top_sva.sv
`timescale 1ns/1ps
`include "olps_consts.svh"
module olps_top_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        enable_pin,
	input wire logic        fallback_pin,
	input wire logic [7:0]  direct_drive_input,
	input wire logic        clk_wake_pin_i,
	input wire logic        clk_wake_pin_oe,
	input wire logic [7:0]  channel_out
);
	logic [12:0] gap_r;
	logic        pin_r;
	// The gap count saturates so a long standby never wraps back into a false edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_r <= 13'h0000;
			pin_r <= 1'b0;
		end else begin
			pin_r <= clk_wake_pin_i;
			if (clk_wake_pin_i && !pin_r) begin
				gap_r <= 13'h0000;
			end else if (gap_r != 13'h1FFF) begin
				gap_r <= gap_r + 13'h0001;
			end
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence idle_low;
		(!enable_pin && !fallback_pin) [*6];
	endsequence
	property p_limp;
		(fallback_pin && enable_pin && $stable(direct_drive_input)) [*6]
			|-> ((channel_out ^ direct_drive_input) & `OLPS_DIRECT_MASK) == 8'h00;
	endproperty
	property p_dead;
		gap_r > 13'h1004 && enable_pin && !fallback_pin && !s_axi_bvalid
			|=> $stable(channel_out);
	endproperty
	AST_WAKE_OE: assert property (idle_low |-> clk_wake_pin_oe)
		else $error("pin not driven in standby");
	AST_CLK_IN: assert property (enable_pin [*6] |-> !clk_wake_pin_oe)
		else $error("pin driven while enabled");
	AST_IDLE_OFF: assert property (idle_low |-> channel_out == 8'h00)
		else $error("outputs on in standby");
	AST_LIMP: assert property (p_limp)
		else $error("limp outputs differ from inputs");
	AST_DEAD_HOLD: assert property (p_dead)
		else $error("outputs move without time base");
	AST_WR_RESP: assert property (wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_RD_LAT: assert property (rd_take |-> ##2 s_axi_rvalid)
		else $error("read data late");
	AST_RD_ERR: assert property (rd_take and s_axi_araddr > 32'h30 |-> ##2
		s_axi_rresp == `OLPS_RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule // olps_top_sva
bind olps_top olps_top_sva olps_top_sva_i (.*);

// File: olps_host_model.sv
`timescale 1ns/1ps
module olps_host_model #(
	parameter int HALF = 4
) (
	input  wire logic aclk,
	input  wire logic run,
	output logic      tb_clk
);
	int cnt = 0;
	// The time base stands low while stopped, so a halt looks like a dead clock.
	initial tb_clk = 1'b0;
	always @(posedge aclk) begin
		if (!run) begin
			tb_clk <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			tb_clk <= ~tb_clk;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // olps_host_model

// File: tb_top.sv
`timescale 1ns/1ps
`include "olps_consts.svh"
module tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b0, host_clk;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        enable_pin = 1'b0, fallback_pin = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        clk_wake_pin_i, clk_wake_pin_o, clk_wake_pin_oe;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0] s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [7:0]  direct_drive_input = 8'h00, channel_out, o0;
	int          fail_count = 0, checks_done = 0, cyc = 0, df;
	int          on [8];
	int          exp_on [8] = '{512, 256, 768, 2048, 2040, 0, 1024, 1024};
	// The shared pin carries whichever side currently enables its driver.
	assign clk_wake_pin_i = clk_wake_pin_oe ? clk_wake_pin_o : host_clk;
	always #25 aclk = ~aclk;
	olps_top olps_top_i (.*);
	olps_host_model olps_host_model_i (.aclk(aclk), .run(run), .tb_clk(host_clk));
	task conclude;
		$display("mismatches %0d comparisons %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic aw_p, w_p;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (aw_p && s_axi_awready) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, `OLPS_RESP_OKAY, "write resp");
	endtask
	task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	function automatic logic [31:0] cw(logic [1:0] g, logic [1:0] s, logic [1:0] p,
		logic [7:0] d);
		return {17'h00000, g, s, p, 1'b0, d};
	endfunction
	task wch(input int i, input logic [31:0] v);
		wr(`OLPS_ADDR_CHAN0 + 32'(4 * i), v);
	endtask
	task meas(input int n);
		on = '{default: 0};
		df = 0;
		repeat (n) begin
			@(posedge aclk);
			for (int i = 0; i < 8; i++) on[i] += int'(channel_out[i]);
			df += int'(channel_out[6] != channel_out[7]);
		end
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(clk_wake_pin_oe, 1'b1, "standby drive");
		chk(channel_out, 8'h00, "standby outputs");
		chk(clk_wake_pin_o, 1'b0, "no wake source");
		direct_drive_input <= 8'h01;
		repeat (5) @(posedge aclk);
		chk(clk_wake_pin_o, 1'b1, "input wake");
		direct_drive_input <= 8'h00;
		repeat (5) @(posedge aclk);
		chk(clk_wake_pin_o, 1'b1, "wake timer runs");
		enable_pin <= 1'b1;
		run <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(clk_wake_pin_oe, 1'b0, "active pin");
		wr(`OLPS_ADDR_GDUTY1, 32'h20);
		wr(`OLPS_ADDR_GDUTY2, 32'h60);
		wch(0, cw(2'h0, 2'h0, 2'h0, 8'h40));
		wch(1, cw(2'h0, 2'h1, 2'h0, 8'h00));
		wch(2, cw(2'h2, 2'h1, 2'h0, 8'h00));
		wch(3, cw(2'h0, 2'h3, 2'h0, 8'h00));
		wch(4, cw(2'h0, 2'h0, 2'h0, 8'hFF));
		wch(5, cw(2'h0, 2'h0, 2'h0, 8'h00));
		wch(6, cw(2'h0, 2'h0, 2'h0, 8'h80));
		wch(7, cw(2'h0, 2'h0, 2'h2, 8'h80));
		wr(`OLPS_ADDR_CTRL, 32'h1FF);
		meas(2100);
		meas(2048);
		for (int i = 0; i < 8; i++) chk(on[i], exp_on[i], "on count");
		chk(df, 2048, "phase opposition");
		@(negedge channel_out[0]);
		wch(0, cw(2'h0, 2'h0, 2'h0, 8'hC0));
		meas(800);
		chk(on[0], 0, "duty held to wrap");
		meas(800);
		meas(2048);
		chk(on[0], 1536, "new duty");
		wch(5, cw(2'h0, 2'h3, 2'h0, 8'h00));
		repeat (4) @(posedge aclk);
		chk(channel_out[5], 1'b1, "full on at once");
		wch(1, cw(2'h3, 2'h3, 2'h0, 8'h00));
		repeat (8) @(posedge aclk);
		o0 = channel_out;
		direct_drive_input <= 8'h02;
		repeat (8) @(posedge aclk);
		chk(channel_out[1], o0[1], "inputs inert");
		direct_drive_input <= 8'h00;
		wr(`OLPS_ADDR_CTRL, 32'h0002_00F7);
		repeat (6) @(posedge aclk);
		chk(channel_out[3], 1'b0, "disabled output");
		chk(channel_out[1], 1'b0, "gate off");
		direct_drive_input <= 8'h02;
		repeat (6) @(posedge aclk);
		chk(channel_out[1], 1'b1, "input high");
		fallback_pin <= 1'b1;
		direct_drive_input <= 8'h25;
		repeat (8) @(posedge aclk);
		chk(channel_out & `OLPS_DIRECT_MASK, 8'h25, "limp");
		fallback_pin <= 1'b0;
		direct_drive_input <= 8'h00;
		run <= 1'b0;
		repeat (3900) @(posedge aclk);
		chk(channel_out[1], 1'b0, "no failure yet");
		repeat (400) @(posedge aclk);
		chk(channel_out, 8'hF7, "outputs from enables");
		run <= 1'b1;
		repeat (50) @(posedge aclk);
		rd(`OLPS_ADDR_STATUS, rv, rr);
		chk(rv[`OLPS_STAT_FAIL_BIT], 1'b1, "flag latched");
		rd(`OLPS_ADDR_STATUS, rv, rr);
		chk(rv[`OLPS_STAT_FAIL_BIT], 1'b0, "flag cleared");
		rd(`OLPS_ADDR_CHAN0, rv, rr);
		chk(rv, 32'h0000_00C0, "channel readback");
		rd(32'h40, rv, rr);
		chk(rr, `OLPS_RESP_SLVERR, "unmapped resp");
		chk(rv, 32'h0, "unmapped data");
		conclude();
	end
endmodule // tb_top
